// ### drive_ctl_pkg.sv
// Shared constants for the drive control-state block
package drive_ctl_pkg;
    // Message identifier bases, eleven bits wide
    localparam logic [10:0] ID_SDO_RX = 11'h600;
    localparam logic [10:0] ID_SDO_TX = 11'h580;
    localparam logic [10:0] ID_TPDO1 = 11'h180;
    localparam logic [10:0] ID_TPDO2 = 11'h280;
    localparam logic [10:0] ID_TPDO3 = 11'h380;
    localparam logic [10:0] ID_TPDO4 = 11'h480;
    localparam logic [10:0] ID_RPDO1 = 11'h200;
    localparam logic [10:0] ID_RPDO2 = 11'h300;
    localparam logic [10:0] ID_RPDO3 = 11'h400;
    localparam logic [10:0] ID_RPDO4 = 11'h500;
    localparam logic [10:0] ID_SYNC = 11'h080;
    localparam logic [10:0] ID_EMCY = 11'h080;
    localparam logic [10:0] ID_HBEAT = 11'h700;
    localparam logic [10:0] ID_NMT = 11'h000;
    // Control word commands, low byte with the documented bit meaning
    localparam logic [7:0] CW_SHUTDOWN = 8'h06;
    localparam logic [7:0] CW_SWITCH_ON = 8'h07;
    localparam logic [7:0] CW_ENABLE = 8'h0f;
    localparam logic [7:0] CW_DISABLE_OP = 8'h07;
    localparam int CW_BIT_VOLT = 1;
    localparam int CW_BIT_QSTOP = 2;
    localparam int CW_BIT_RESET = 7;
    // Status word state codes, profile coding
    localparam logic [15:0] SW_NOT_READY = 16'h0000;
    localparam logic [15:0] SW_DISABLED = 16'h0040;
    localparam logic [15:0] SW_READY = 16'h0021;
    localparam logic [15:0] SW_ON = 16'h0023;
    localparam logic [15:0] SW_ENABLED = 16'h0027;
    localparam logic [15:0] SW_QSTOP = 16'h0007;
    localparam logic [15:0] SW_FAULT_REACT = 16'h000f;
    localparam logic [15:0] SW_FAULT = 16'h0008;
    // Timing: lamp half period and built-in reaction times
    localparam int BLINK_HALF_MS = 250;
    localparam int CLK_MHZ = 125;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
    localparam int SELFTEST_US = 100;
    localparam int SELFTEST_CYC = SELFTEST_US * CLK_MHZ;
    localparam int REACT_US = 10;
    localparam int REACT_CYC = REACT_US * CLK_MHZ;
    // Profile states, Gray along power-up and enable path
    typedef enum logic [2:0] {
        ST_NOT_READY = 3'h0,
        ST_DISABLED = 3'h1,
        ST_READY = 3'h3,
        ST_ON = 3'h2,
        ST_ENABLED = 3'h6,
        ST_QSTOP = 3'h7,
        ST_FAULT_REACT = 3'h5,
        ST_FAULT = 3'h4
    } drive_state_t;
endpackage : drive_ctl_pkg

// ### drive_state_machine.sv
// Profile state machine, identifiers and status lamps of the drive
// Contract
// - Service requests arrive on 600h plus node number, only that one.
// - Service responses leave on 580h plus node number.
// - TPDO 180h..480h, RPDO 200h..500h, each plus node number.
// - SYNC 80h, emergency 80h+node, heartbeat 700h+node, NMT zero.
// - State changes only on internal events or control word commands.
// - After initialisation move alone to switch-on-disabled, then wait.
// - Self test in not-ready state; communication enabled only after.
// - No command returns below switch-on-disabled.
// - Status word uses the standard profile state coding.
// - Saving allowed except in operation-enabled and quick-stop states; code also blocks saving in not-ready.
// - Switched-on: power stage ready, no motor power, function off.
// - Operation-enabled: motor power, function on, brake released.
// - Quick-stop-active: motion halted, torque still applied.
// - Fault enters reaction state, then fault; reaction state hidden; code ignores a fault in not-ready.
// - Fault state: function off, fault reset accepted.
// - Extra safety state entered while emergency input applied.
// - Lamps: switched-on blink/off, enabled on/off, quickstop on/on.
// - Not-ready both blink, disabled/ready alternate, safety, comm error.
// - Commands 06h, 07h, 0Fh step to ready, on, enabled.
// - Quick stop command in enabled stops at once, no ramp.
`timescale 1ns/100ps
module drive_state_machine
    import drive_ctl_pkg::*;
#(
    parameter int SELFTEST_CYCLES = SELFTEST_CYC,
    parameter int REACT_CYCLES = REACT_CYC,
    parameter int BLINK_CYCLES = BLINK_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Node address and received message
    input wire logic [6:0] node_number_i,
    input wire logic rx_valid_i,
    input wire logic [10:0] rx_id_i,
    // Control word written by the master
    input wire logic cw_valid_i,
    input wire logic [15:0] cw_i,
    // Internal events, asynchronous pins
    input wire logic fault_i,
    input wire logic emergency_i,
    input wire logic comm_error_i,
    // Identifiers for outgoing and received traffic, own request match
    output logic [10:0] id_sdo_tx_o,
    output logic [10:0] id_emcy_o,
    output logic [10:0] id_hbeat_o,
    output logic [43:0] id_tpdo_o,
    output logic [43:0] id_rpdo_o,
    output logic sdo_hit_o,
    // State report and drive controls
    output logic [15:0] status_word_o,
    output logic comm_enable_o,
    output logic save_allowed_o,
    output logic power_ready_o,
    output logic motor_power_o,
    output logic function_enable_o,
    output logic brake_release_o,
    output logic safety_o,
    // Status lamps
    output logic led_green_o,
    output logic led_yellow_o
);
    initial begin
        if (SELFTEST_CYCLES < 1 || REACT_CYCLES < 1 || BLINK_CYCLES < 2)
            $error("drive_state_machine: counts too small");
    end

    localparam int TW = 32;
    localparam logic [10:0] TX_BASE [4] = '{ID_TPDO1, ID_TPDO2, ID_TPDO3,
                                           ID_TPDO4};
    localparam logic [10:0] RX_BASE [4] = '{ID_RPDO1, ID_RPDO2, ID_RPDO3,
                                           ID_RPDO4};

    // Pin synchronisers, first stage read only by second
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {comm_error_i, emergency_i, fault_i};
            sync_b <= sync_a;
        end
    end
    wire fault_s = sync_b[0];
    wire emerg_s = sync_b[1];
    wire comm_s = sync_b[2];

    // Identifier generation
    logic [10:0] node_ext;
    logic [10:0] next_sdo_tx, next_emcy, next_hbeat;
    logic [43:0] next_tpdo, next_rpdo;
    logic next_hit;
    always_comb begin
        node_ext = {4'h0, node_number_i};
        next_sdo_tx = ID_SDO_TX + node_ext;
        next_emcy = ID_EMCY + node_ext;
        next_hbeat = ID_HBEAT + node_ext;
        next_hit = rx_valid_i && (rx_id_i == ID_SDO_RX + node_ext);
    end
    for (genvar g = 0; g < 4; g++) begin : g_pdo
        assign next_tpdo[g*11 +: 11] = TX_BASE[g] + node_ext;
        assign next_rpdo[g*11 +: 11] = RX_BASE[g] + node_ext;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            id_sdo_tx_o <= 11'h000;
            id_emcy_o <= 11'h000;
            id_hbeat_o <= 11'h000;
            id_tpdo_o <= 44'h0;
            id_rpdo_o <= 44'h0;
            sdo_hit_o <= 1'b0;
        end else begin
            id_sdo_tx_o <= next_sdo_tx;
            id_emcy_o <= next_emcy;
            id_hbeat_o <= next_hbeat;
            id_tpdo_o <= next_tpdo;
            id_rpdo_o <= next_rpdo;
            sdo_hit_o <= next_hit;
        end
    end

    // Profile state machine with self-test and reaction timer
    drive_state_t state, next_state;
    logic [TW-1:0] tmr, next_tmr;
    logic [7:0] cw;
    always_comb begin
        next_state = state;
        next_tmr = tmr;
        cw = cw_i[7:0];
        unique case (state)
            ST_NOT_READY: begin
                if (tmr >= TW'(SELFTEST_CYCLES - 1))
                    next_state = ST_DISABLED;
                else
                    next_tmr = tmr + 1'b1;
            end
            ST_FAULT_REACT: begin
                if (tmr >= TW'(REACT_CYCLES - 1))
                    next_state = ST_FAULT;
                else
                    next_tmr = tmr + 1'b1;
            end
            ST_FAULT: begin
                if (cw_valid_i && cw_i[CW_BIT_RESET])
                    next_state = ST_DISABLED;
            end
            ST_DISABLED: begin
                if (cw_valid_i && cw == CW_SHUTDOWN)
                    next_state = ST_READY;
            end
            ST_READY: begin
                if (cw_valid_i && cw == CW_SWITCH_ON)
                    next_state = ST_ON;
                else if (cw_valid_i && !cw_i[CW_BIT_VOLT])
                    next_state = ST_DISABLED;
            end
            ST_ON: begin
                if (cw_valid_i && cw == CW_ENABLE)
                    next_state = ST_ENABLED;
                else if (cw_valid_i && cw == CW_SHUTDOWN)
                    next_state = ST_READY;
                else if (cw_valid_i && !cw_i[CW_BIT_VOLT])
                    next_state = ST_DISABLED;
            end
            ST_ENABLED: begin
                if (cw_valid_i && cw_i[CW_BIT_VOLT] && !cw_i[CW_BIT_QSTOP])
                    next_state = ST_QSTOP;
                else if (cw_valid_i && cw == CW_DISABLE_OP)
                    next_state = ST_ON;
                else if (cw_valid_i && cw == CW_SHUTDOWN)
                    next_state = ST_READY;
                else if (cw_valid_i && !cw_i[CW_BIT_VOLT])
                    next_state = ST_DISABLED;
            end
            ST_QSTOP: begin
                if (cw_valid_i && !cw_i[CW_BIT_VOLT])
                    next_state = ST_DISABLED;
            end
        endcase
        if (fault_s && state != ST_NOT_READY && state != ST_FAULT_REACT &&
            state != ST_FAULT) begin
            next_state = ST_FAULT_REACT;
            next_tmr = '0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_NOT_READY;
            tmr <= '0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
        end
    end

    // Outputs except safety_o decoded from next state so they align with the state flop
    logic [15:0] next_sw;
    logic next_save, next_pready, next_mpower, next_func, next_comm;
    always_comb begin
        next_sw = SW_NOT_READY;
        next_save = 1'b0;
        next_pready = 1'b0;
        next_mpower = 1'b0;
        next_func = 1'b0;
        next_comm = next_state != ST_NOT_READY;
        // reaction reported as fault, kept hidden
        unique case (next_state)
            ST_NOT_READY: next_sw = SW_NOT_READY;
            ST_DISABLED: next_sw = SW_DISABLED;
            ST_READY: next_sw = SW_READY;
            ST_ON: next_sw = SW_ON;
            ST_ENABLED: next_sw = SW_ENABLED;
            ST_QSTOP: next_sw = SW_QSTOP;
            ST_FAULT_REACT: next_sw = SW_FAULT;
            ST_FAULT: next_sw = SW_FAULT;
        endcase
        next_save = next_state inside {ST_DISABLED, ST_READY, ST_ON,
                                       ST_FAULT, ST_FAULT_REACT};
        next_pready = next_state inside {ST_ON, ST_ENABLED, ST_QSTOP};
        next_mpower = next_state inside {ST_ENABLED, ST_QSTOP};
        next_func = next_mpower;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_word_o <= SW_NOT_READY;
            save_allowed_o <= 1'b0;
            power_ready_o <= 1'b0;
            motor_power_o <= 1'b0;
            function_enable_o <= 1'b0;
            brake_release_o <= 1'b0;
            comm_enable_o <= 1'b0;
            safety_o <= 1'b0;
        end else begin
            status_word_o <= next_sw;
            save_allowed_o <= next_save;
            power_ready_o <= next_pready;
            motor_power_o <= next_mpower;
            function_enable_o <= next_func;
            brake_release_o <= next_state == ST_ENABLED;
            comm_enable_o <= next_comm;
            safety_o <= emerg_s;
        end
    end

    // Blink timebase; one shared phase keeps lamps in step
    logic [TW-1:0] blink_cnt, next_blink_cnt;
    logic phase, next_phase;
    logic next_green, next_yellow;
    always_comb begin
        next_blink_cnt = blink_cnt + 1'b1;
        next_phase = phase;
        if (blink_cnt >= TW'(BLINK_CYCLES - 1)) begin
            next_blink_cnt = '0;
            next_phase = !phase;
        end
        // init, safety and comm error codes
        if (safety_o) begin
            next_green = 1'b0;
            next_yellow = phase;
        end else if (comm_s) begin
            next_green = 1'b0;
            next_yellow = 1'b1;
        end else begin
            unique case (state)
                ST_NOT_READY: {next_green, next_yellow} = {phase, phase};
                ST_DISABLED, ST_READY:
                    {next_green, next_yellow} = {phase, !phase};
                ST_ON: {next_green, next_yellow} = {phase, 1'b0};
                ST_ENABLED: {next_green, next_yellow} = 2'h2;
                ST_QSTOP: {next_green, next_yellow} = 2'h3;
                ST_FAULT_REACT, ST_FAULT:
                    {next_green, next_yellow} = {phase, phase};
            endcase
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            blink_cnt <= '0;
            phase <= 1'b0;
            led_green_o <= 1'b0;
            led_yellow_o <= 1'b0;
        end else begin
            blink_cnt <= next_blink_cnt;
            phase <= next_phase;
            led_green_o <= next_green;
            led_yellow_o <= next_yellow;
        end
    end

    // Checks
    // shutdown from disabled
    a_shutdown_step: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_DISABLED && cw_valid_i && cw == CW_SHUTDOWN && !fault_s
        |=> state == ST_READY && status_word_o == SW_READY)
        else $error("shutdown did not reach ready");
    a_qstop_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_ENABLED && cw_valid_i && cw_i[CW_BIT_VOLT] &&
        !cw_i[CW_BIT_QSTOP] && !fault_s |=> state == ST_QSTOP)
        else $error("quick stop not entered");
    a_react_hidden: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_FAULT_REACT |-> status_word_o == SW_FAULT)
        else $error("fault reaction visible");
    a_save_block: assert property (@(posedge clk_i) disable iff (rst_i)
        state inside {ST_ENABLED, ST_QSTOP} |-> !save_allowed_o)
        else $error("save allowed while running");
    a_comm_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_NOT_READY |-> !comm_enable_o)
        else $error("communication during self test");
    a_on_nopower: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_ON |-> power_ready_o && !motor_power_o)
        else $error("switched-on power wrong");
    a_no_reinit: assert property (@(posedge clk_i) disable iff (rst_i)
        state != ST_NOT_READY |=> state != ST_NOT_READY)
        else $error("returned to init state");
    a_sdo_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_valid_i && rx_id_i == ID_SDO_RX + {4'h0, node_number_i}
        |=> sdo_hit_o)
        else $error("own request missed");
endmodule : drive_state_machine

// ### drive_master_model.sv
// Network master model that writes control words and sends frames
`timescale 1ns/100ps
module drive_master_model (
    // Clock
    input wire logic clk_i,
    // Control word channel
    output logic cw_valid_o,
    output logic [15:0] cw_o,
    // Received frame channel
    output logic rx_valid_o,
    output logic [10:0] rx_id_o
);
    // Idle lines carry a pattern, never a held copy of the last word
    initial begin
        cw_valid_o = 1'b0;
        cw_o = 16'h5a5a;
        rx_valid_o = 1'b0;
        rx_id_o = 11'h2a5;
    end

    task automatic send_cw(input logic [15:0] value);
        @(posedge clk_i);
        #1;
        cw_valid_o = 1'b1;
        cw_o = value;
        @(posedge clk_i);
        #1;
        cw_valid_o = 1'b0;
        cw_o = ~value; // Released word shows its inverse
    endtask : send_cw

    task automatic send_frame(input logic [10:0] id);
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b1;
        rx_id_o = id;
        @(posedge clk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_id_o = ~id; // Released bus shows its inverse
    endtask : send_frame
endmodule : drive_master_model

// ### tb_drive_state_machine_can_ids.sv
// Self-checking bench for the drive control-state block
`timescale 1ns/100ps
module tb_drive_state_machine_can_ids
    import drive_ctl_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [6:0] node_number_i = 7'h00;
    logic fault_i = 1'b0;
    logic emergency_i = 1'b0;
    logic comm_error_i = 1'b0;
    logic rx_valid_i, cw_valid_i, sdo_hit_o, comm_enable_o;
    logic [10:0] rx_id_i, id_sdo_tx_o, id_emcy_o, id_hbeat_o;
    logic [43:0] id_tpdo_o, id_rpdo_o;
    logic [15:0] cw_i, status_word_o;
    logic save_allowed_o, power_ready_o, motor_power_o, function_enable_o;
    logic brake_release_o, safety_o, led_green_o, led_yellow_o;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'h49aa;
    logic [15:0] sw_q[$];
    logic hit_q[$];

    // Short counts keep the run brief
    drive_state_machine #(.SELFTEST_CYCLES(4), .REACT_CYCLES(3),
        .BLINK_CYCLES(4)) dut (.clk_i, .rst_i, .node_number_i, .rx_valid_i,
        .rx_id_i, .cw_valid_i, .cw_i, .fault_i, .emergency_i, .comm_error_i,
        .id_sdo_tx_o, .id_emcy_o, .id_hbeat_o, .id_tpdo_o, .id_rpdo_o,
        .sdo_hit_o, .status_word_o, .comm_enable_o, .save_allowed_o,
        .power_ready_o, .motor_power_o, .function_enable_o, .brake_release_o,
        .safety_o, .led_green_o, .led_yellow_o);

    drive_master_model master (.clk_i(clk_i), .cw_valid_o(cw_valid_i),
        .cw_o(cw_i), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i));

    // Clock at 125 MHz
    always #4 clk_i = ~clk_i;

    task automatic check(input logic [43:0] seen, input logic [43:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic complete_run();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // Note the expected status, then let the master write the word
    task automatic cmd(input logic [15:0] value, input logic [15:0] exp);
        sw_q.push_back(exp);
        master.send_cw(value);
    endtask : cmd

    task automatic frame(input logic [10:0] id);
        hit_q.push_back(id === 11'h600 + node_number_i);
        master.send_frame(id);
    endtask : frame

    // Bounded wait, so a stuck state machine cannot hang the run
    task automatic wait_status(input logic [15:0] exp);
        int n;
        n = 0;
        while (status_word_o !== exp && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        #2;
        check(status_word_o, exp);
    endtask : wait_status

    // Count lit samples over 16 cycles, so any blink phase gives 8
    task automatic lamps(input int g, input int y, input int eq);
        int ng, ny, ne;
        ng = 0;
        ny = 0;
        ne = 0;
        repeat (4) @(posedge clk_i);
        repeat (16) begin
            @(negedge clk_i);
            ng += int'(led_green_o === 1'b1);
            ny += int'(led_yellow_o === 1'b1);
            ne += int'(led_green_o === led_yellow_o);
        end
        check(ng, g);
        check(ny, y);
        check(ne, eq);
        @(posedge clk_i);
        #1;
    endtask : lamps

    // Oldest noted status compared once the command has landed
    always @(posedge clk_i) begin
        if (cw_valid_i === 1'b1) begin
            @(posedge clk_i);
            #2;
            check(status_word_o, sw_q.pop_front());
        end
    end

    // Address match flag compared in each cycle a frame is presented
    always @(posedge clk_i) begin
        if (rx_valid_i === 1'b1) begin
            #2;
            check(sdo_hit_o, hit_q.pop_front());
        end
    end

    // Hidden reaction code and the hang limit
    always @(negedge clk_i) begin
        if (status_word_o === SW_FAULT_REACT) begin
            check(status_word_o, 16'h0008);
        end
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        logic [6:0] nd;
        logic [10:0] rid;
        logic [10:0] base;
        repeat (3) @(posedge clk_i);
        #2;
        check(status_word_o, 16'h0000);
        check(comm_enable_o, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        @(posedge clk_i);
        #2;
        check(comm_enable_o, 1'b0);
        wait_status(16'h0040);
        repeat (2) @(posedge clk_i);
        #2;
        check(comm_enable_o, 1'b1);
        repeat (4) begin
            nd = 7'($random(seed));
            rid = 11'($random(seed));
            @(posedge clk_i);
            #1;
            node_number_i = nd;
            repeat (2) @(posedge clk_i);
            #2;
            check(id_sdo_tx_o, 11'h580 + nd);
            check(id_emcy_o, 11'h080 + nd);
            check(id_hbeat_o, 11'h700 + nd);
            for (int k = 0; k < 4; k++) begin
                base = 11'(k) << 8;
                check(id_tpdo_o[k*11+:11], 11'h180 + base + nd);
                check(id_rpdo_o[k*11+:11], 11'h200 + base + nd);
            end
            frame(11'h600 + nd);
            frame(11'h580 + nd);
            frame(rid);
        end
        cmd(16'h0006, 16'h0021);
        cmd(16'h0007, 16'h0023);
        lamps(8, 0, 8);
        check(power_ready_o, 1'b1);
        check(motor_power_o, 1'b0);
        check(function_enable_o, 1'b0);
        check(save_allowed_o, 1'b1);
        cmd(16'h000f, 16'h0027);
        lamps(16, 0, 0);
        check(motor_power_o, 1'b1);
        check(function_enable_o, 1'b1);
        check(brake_release_o, 1'b1);
        check(save_allowed_o, 1'b0);
        cmd(16'h0002, 16'h0007);
        lamps(16, 16, 16);
        check(motor_power_o, 1'b1);
        check(save_allowed_o, 1'b0);
        cmd(16'h0000, 16'h0040);
        lamps(8, 8, 0);
        cmd(16'h000f, 16'h0040);
        cmd(16'h0000, 16'h0040);
        cmd(16'h0006, 16'h0021);
        fault_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        fault_i = 1'b0;
        wait_status(16'h0008);
        lamps(8, 8, 16);
        check(function_enable_o, 1'b0);
        check(save_allowed_o, 1'b1);
        cmd(16'h0080, 16'h0040);
        emergency_i = 1'b1;
        lamps(0, 8, 8);
        check(safety_o, 1'b1);
        emergency_i = 1'b0;
        comm_error_i = 1'b1;
        lamps(0, 16, 0);
        comm_error_i = 1'b0;
        complete_run();
    end
endmodule : tb_drive_state_machine_can_ids
